/* hdl/avm_pkg.sv */
// Overview of operation
// - a violation captures the core's 24-bit pc; software reads it, never writes it
// - captured pc is the address of the offending instruction itself
// - after the error code is cleared the captured pc means nothing
// - every access is decoded by address into a region of a 16MB space
// - core, debug, ADCs and trigger unit share the space; accesses carry initiator
// - legality looked up by region, access kind and initiator
// - core write to reserved space legal only in special single-chip mode
// - an NVM access colliding with a running NVM command is illegal
// - every illegal core access raises a machine exception
// - illegal debug access sets the debug illegal-access flag, no exception
// - illegal ADC or trigger-unit access raises that module's error interrupt
// - illegal opcode prefetch raises a machine exception even if never executed
// - uncorrectable ECC on core, ADC or trigger access raises a machine exception
// - uncorrectable ECC on debug access sets write-fault or read-invalid flag only
// - non-zero error code freezes error code, captured pc and condition codes
// - writing 0xFFFF to the error code pair clears it and re-arms capture
// - initiator and target fields of the error code use the fixed codes
// - access type and error type fields use the fixed codes
package avm_pkg;

    localparam int AVM_AW = 24;

    typedef enum logic [2:0] {
        AVM_INI_CPU, AVM_INI_DBG, AVM_INI_ADC0, AVM_INI_ADC1, AVM_INI_TRIG
    } avm_ini_t;

    typedef enum logic [1:0] {
        AVM_ACC_OPCODE, AVM_ACC_VECTOR, AVM_ACC_LOAD, AVM_ACC_STORE
    } avm_kind_t;

    typedef enum logic [2:0] {
        AVM_RGN_REG, AVM_RGN_RSV, AVM_RGN_RSV_RO, AVM_RGN_RAM,
        AVM_RGN_EEP, AVM_RGN_IFR, AVM_RGN_PNVM, AVM_RGN_UNMAP
    } avm_rgn_t;

    // one access as it completes on the internal bus
    typedef struct packed {
        logic              valid;
        avm_ini_t          ini;
        avm_kind_t         kind;
        logic [AVM_AW-1:0] addr;
        logic              ecc_fault;
        logic              nvm_collision;
    } avm_access_t;

    // core state belonging to the instruction that owns the access
    typedef struct packed {
        logic [AVM_AW-1:0] pc;
        logic              user;
        logic              xmask;
        logic              imask;
    } avm_core_ctx_t;

    typedef struct packed {
        logic [3:0] initiator_field;
        logic [3:0] target_field;
        logic [3:0] access_type_field;
        logic [3:0] err_type;
    } avm_err_code_t;

    // register indexes; byte address is four times the index
    localparam logic [7:0] AVM_IDX_MODE = 8'h70;
    localparam logic [7:0] AVM_IDX_ECH  = 8'h80;
    localparam logic [7:0] AVM_IDX_ECL  = 8'h81;
    localparam logic [7:0] AVM_IDX_CCRH = 8'h82;
    localparam logic [7:0] AVM_IDX_CCRL = 8'h83;
    localparam logic [7:0] AVM_IDX_PCH  = 8'h84;
    localparam logic [7:0] AVM_IDX_PCM  = 8'h85;
    localparam logic [7:0] AVM_IDX_PCL  = 8'h86;

    localparam int AVM_MODC_BIT = 7;
    localparam int AVM_USER_BIT = 7;
    localparam int AVM_XMSK_BIT = 6;
    localparam int AVM_IMSK_BIT = 4;

    localparam logic [15:0]       AVM_EC_CLEAR = 16'hFFFF;
    localparam logic [15:0]       AVM_EC_RESET = 16'h0000;
    localparam logic [AVM_AW-1:0] AVM_PC_RESET = 24'h000000;

    localparam logic [3:0] AVM_ITR_NONE = 4'h0;
    localparam logic [3:0] AVM_ITR_CPU  = 4'h1;
    localparam logic [3:0] AVM_ITR_ADC0 = 4'h3;
    localparam logic [3:0] AVM_ITR_ADC1 = 4'h4;
    localparam logic [3:0] AVM_ITR_TRIG = 4'h5;

    localparam logic [3:0] AVM_TGT_NONE = 4'h0;
    localparam logic [3:0] AVM_TGT_REG  = 4'h1;
    localparam logic [3:0] AVM_TGT_RAM  = 4'h2;
    localparam logic [3:0] AVM_TGT_EEP  = 4'h3;
    localparam logic [3:0] AVM_TGT_PFL  = 4'h4;
    localparam logic [3:0] AVM_TGT_IFR  = 4'h5;

    localparam logic [3:0] AVM_ACC_F_OPC = 4'h1;
    localparam logic [3:0] AVM_ACC_F_VEC = 4'h2;
    localparam logic [3:0] AVM_ACC_F_LD  = 4'h3;
    localparam logic [3:0] AVM_ACC_F_ST  = 4'h4;

    localparam logic [3:0] AVM_ERR_ILL = 4'h1;
    localparam logic [3:0] AVM_ERR_ECC = 4'h2;

    // region map by address[23:20]; program NVM fills the upper half
    localparam logic [3:0]        AVM_PG_LOW   = 4'h0;
    localparam logic [3:0]        AVM_PG_RSVRO = 4'h1;
    localparam logic [3:0]        AVM_PG_RAM   = 4'h2;
    localparam logic [3:0]        AVM_PG_EEP   = 4'h3;
    localparam logic [3:0]        AVM_PG_IFR   = 4'h4;
    localparam logic [3:0]        AVM_PG_PNVM  = 4'h8;
    localparam logic [AVM_AW-1:0] AVM_REG_TOP  = 24'h000FFF;

endpackage

/* hdl/avm_legality.sv */
`timescale 1ns/1ps
`default_nettype none
module avm_legality (
    input  wire logic [23:0]       addr,
    input  wire avm_pkg::avm_ini_t  ini,
    input  wire avm_pkg::avm_kind_t kind,
    input  wire logic              special_mode,
    input  wire logic              collision,
    output avm_pkg::avm_rgn_t      rgn,
    output logic [3:0]             tgt_code,
    output logic                   illegal
);
    wire logic [3:0] page   = addr[23:20];
    wire logic       is_cpu = (ini == avm_pkg::AVM_INI_CPU);
    wire logic       is_dbg = (ini == avm_pkg::AVM_INI_DBG);
    wire logic       is_dma = !is_cpu && !is_dbg;
    // vector fetches are reads of the table, only opcodes execute
    wire logic       is_x   = (kind == avm_pkg::AVM_ACC_OPCODE);
    wire logic       is_w   = (kind == avm_pkg::AVM_ACC_STORE);
    wire logic       is_r   = !is_x && !is_w;
    logic            tbl_bad;

    assign rgn =
        (page == avm_pkg::AVM_PG_LOW) ?
            ((addr <= avm_pkg::AVM_REG_TOP) ? avm_pkg::AVM_RGN_REG
                                            : avm_pkg::AVM_RGN_RSV) :
        (page == avm_pkg::AVM_PG_RSVRO) ? avm_pkg::AVM_RGN_RSV_RO :
        (page == avm_pkg::AVM_PG_RAM)   ? avm_pkg::AVM_RGN_RAM :
        (page == avm_pkg::AVM_PG_EEP)   ? avm_pkg::AVM_RGN_EEP :
        (page == avm_pkg::AVM_PG_IFR)   ? avm_pkg::AVM_RGN_IFR :
        (page >= avm_pkg::AVM_PG_PNVM)  ? avm_pkg::AVM_RGN_PNVM :
                                          avm_pkg::AVM_RGN_UNMAP;

    wire logic is_nvm = (rgn == avm_pkg::AVM_RGN_EEP)
                     || (rgn == avm_pkg::AVM_RGN_IFR)
                     || (rgn == avm_pkg::AVM_RGN_PNVM);

    // only the core executes; any other initiator fetching code is illegal
    always_comb begin
        tbl_bad = 1'b1;
        unique case (rgn)
            avm_pkg::AVM_RGN_REG:    tbl_bad = is_dma || is_x;
            avm_pkg::AVM_RGN_RAM:    tbl_bad = is_x && !is_cpu;
            avm_pkg::AVM_RGN_EEP:    tbl_bad = is_w || (is_x && !is_cpu);
            avm_pkg::AVM_RGN_RSV:    tbl_bad = is_dma || is_x
                                      || (is_cpu && is_w && !special_mode);
            avm_pkg::AVM_RGN_RSV_RO: tbl_bad = is_dma || !is_r;
            avm_pkg::AVM_RGN_IFR:    tbl_bad = is_dma || !is_r;
            avm_pkg::AVM_RGN_PNVM:   tbl_bad = is_w || (is_x && !is_cpu);
            avm_pkg::AVM_RGN_UNMAP:  tbl_bad = 1'b1;
        endcase
    end

    assign illegal = tbl_bad || (is_nvm && collision);

    assign tgt_code =
        (rgn == avm_pkg::AVM_RGN_REG)  ? avm_pkg::AVM_TGT_REG :
        (rgn == avm_pkg::AVM_RGN_RAM)  ? avm_pkg::AVM_TGT_RAM :
        (rgn == avm_pkg::AVM_RGN_EEP)  ? avm_pkg::AVM_TGT_EEP :
        (rgn == avm_pkg::AVM_RGN_PNVM) ? avm_pkg::AVM_TGT_PFL :
        (rgn == avm_pkg::AVM_RGN_IFR)  ? avm_pkg::AVM_TGT_IFR :
                                         avm_pkg::AVM_TGT_NONE;
endmodule
`default_nettype wire

/* hdl/avm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module avm_top #(
    parameter int PAW = 12
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PAW-1:0]        paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  mode_strap,
    input  wire avm_pkg::avm_access_t   access,
    input  wire avm_pkg::avm_core_ctx_t core_ctx,
    output logic                       special_mode,
    output logic                       machine_exception,
    output logic                       dbg_illegal_access_set,
    output logic                       dbg_ram_write_fault_set,
    output logic                       dbg_read_invalid_set,
    output logic                       adc0_error_irq,
    output logic                       adc1_error_irq,
    output logic                       trig_error_irq
);
    // ---------------- access classification ----------------
    avm_pkg::avm_rgn_t rgn;
    logic [3:0]        tgt_code;
    logic              illegal;
    logic              modc;

    avm_legality avm_legality_inst (
        .addr         (access.addr),
        .ini          (access.ini),
        .kind         (access.kind),
        .special_mode (special_mode),
        .collision    (access.nvm_collision),
        .rgn          (rgn),
        .tgt_code     (tgt_code),
        .illegal      (illegal)
    );

    wire logic from_cpu  = (access.ini == avm_pkg::AVM_INI_CPU);
    wire logic from_dbg  = (access.ini == avm_pkg::AVM_INI_DBG);
    wire logic from_adc0 = (access.ini == avm_pkg::AVM_INI_ADC0);
    wire logic from_adc1 = (access.ini == avm_pkg::AVM_INI_ADC1);
    wire logic from_trig = (access.ini == avm_pkg::AVM_INI_TRIG);
    wire logic is_store  = (access.kind == avm_pkg::AVM_ACC_STORE);

    // purely combinational, so a legal access sees no extra wait state
    wire logic acc_ill = access.valid && illegal;
    wire logic acc_ecc = access.valid && access.ecc_fault;

    // a prefetch shows up as an opcode fetch whether or not it executes
    assign machine_exception = (from_cpu && acc_ill)
                            || (acc_ecc && !from_dbg);
    assign dbg_illegal_access_set  = from_dbg && acc_ill;
    assign dbg_ram_write_fault_set = from_dbg && acc_ecc && is_store;
    assign dbg_read_invalid_set    = from_dbg && acc_ecc && !is_store;
    assign adc0_error_irq = from_adc0 && acc_ill;
    assign adc1_error_irq = from_adc1 && acc_ill;
    assign trig_error_irq = from_trig && acc_ill;

    // ---------------- APB decode ----------------
    wire logic [7:0] idx      = paddr[9:2];
    wire logic       apb_acc  = psel && penable;
    wire logic       apb_wr   = apb_acc && pwrite;
    wire logic       apb_setup = psel && !penable;

    wire logic hit_mode = (idx == avm_pkg::AVM_IDX_MODE);
    wire logic hit_ech  = (idx == avm_pkg::AVM_IDX_ECH);
    wire logic hit_ecl  = (idx == avm_pkg::AVM_IDX_ECL);
    wire logic hit_ccrh = (idx == avm_pkg::AVM_IDX_CCRH);
    wire logic hit_ccrl = (idx == avm_pkg::AVM_IDX_CCRL);
    wire logic hit_pch  = (idx == avm_pkg::AVM_IDX_PCH);
    wire logic hit_pcm  = (idx == avm_pkg::AVM_IDX_PCM);
    wire logic hit_pcl  = (idx == avm_pkg::AVM_IDX_PCL);
    wire logic hit_any  = hit_mode || hit_ech || hit_ecl || hit_ccrh
                       || hit_ccrl || hit_pch || hit_pcm || hit_pcl;

    assign pready  = 1'b1;
    assign pslverr = apb_acc && !hit_any;

    // ---------------- mode ----------------
    logic strap_taken;

    // modc low means special single-chip; only leaving it is allowed
    wire logic mode_wr = apb_wr && hit_mode && !modc
                      && pwdata[avm_pkg::AVM_MODC_BIT];
    assign special_mode = !modc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_taken <= 1'b0;
        end else begin
            strap_taken <= 1'b1;
        end
    end

    // strap is caught on the first edge after release, not in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modc <= 1'b0;
        end else if (!strap_taken) begin
            modc <= mode_strap;
        end else if (mode_wr) begin
            modc <= 1'b1;
        end
    end

    // ---------------- error capture ----------------
    avm_pkg::avm_err_code_t err_code;
    logic [23:0]            cap_pc;
    logic                   cap_user;
    logic                   cap_xmask;
    logic                   cap_imask;

    wire logic ec_zero  = (err_code == avm_pkg::AVM_EC_RESET);
    wire logic ec_clear = apb_wr && (hit_ech || hit_ecl)
                       && (pwdata[15:0] == avm_pkg::AVM_EC_CLEAR);
    // debug faults go to the debug flags and never reach the record
    wire logic cap_event = (acc_ill || acc_ecc) && !from_dbg;
    // an event in the clearing cycle is kept: capture wins over clear
    wire logic do_capture = cap_event && (ec_zero || ec_clear);

    wire logic [3:0] next_itr =
        from_cpu  ? avm_pkg::AVM_ITR_CPU :
        from_adc0 ? avm_pkg::AVM_ITR_ADC0 :
        from_adc1 ? avm_pkg::AVM_ITR_ADC1 :
        from_trig ? avm_pkg::AVM_ITR_TRIG : avm_pkg::AVM_ITR_NONE;

    wire logic [3:0] next_acc =
        (access.kind == avm_pkg::AVM_ACC_OPCODE) ? avm_pkg::AVM_ACC_F_OPC :
        (access.kind == avm_pkg::AVM_ACC_VECTOR) ? avm_pkg::AVM_ACC_F_VEC :
        (access.kind == avm_pkg::AVM_ACC_LOAD)   ? avm_pkg::AVM_ACC_F_LD :
                                                   avm_pkg::AVM_ACC_F_ST;

    // an illegal access outranks an ECC fault in the same access
    wire logic [3:0] next_err = acc_ill ? avm_pkg::AVM_ERR_ILL
                                        : avm_pkg::AVM_ERR_ECC;

    wire avm_pkg::avm_err_code_t next_err_code =
        '{next_itr, tgt_code, next_acc, next_err};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_code <= avm_pkg::AVM_EC_RESET;
        end else if (do_capture) begin
            err_code <= next_err_code;
        end else if (ec_clear) begin
            err_code <= avm_pkg::AVM_EC_RESET;
        end
    end

    // pc and ccr are left alone on clear; they mean nothing until next fault
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_pc    <= avm_pkg::AVM_PC_RESET;
            cap_user  <= 1'b0;
            cap_xmask <= 1'b0;
            cap_imask <= 1'b0;
        end else if (do_capture) begin
            cap_pc    <= core_ctx.pc;
            cap_user  <= core_ctx.user;
            cap_xmask <= core_ctx.xmask;
            cap_imask <= core_ctx.imask;
        end
    end

    // ---------------- read data ----------------
    logic [7:0] ccrh_val;
    logic [7:0] ccrl_val;

    always_comb begin
        ccrh_val = 8'h00;
        ccrl_val = 8'h00;
        ccrh_val[avm_pkg::AVM_USER_BIT] = cap_user;
        ccrl_val[avm_pkg::AVM_XMSK_BIT] = cap_xmask;
        ccrl_val[avm_pkg::AVM_IMSK_BIT] = cap_imask;
    end

    wire logic [7:0] mode_val = {modc, 7'h00};
    wire logic [7:0] ech_val  = {err_code.initiator_field,
                                 err_code.target_field};
    wire logic [7:0] ecl_val  = {err_code.access_type_field,
                                 err_code.err_type};

    // captured pc bytes are read only: writes to them are dropped
    wire logic [7:0] rd_byte =
        hit_mode ? mode_val :
        hit_ech  ? ech_val :
        hit_ecl  ? ecl_val :
        hit_ccrh ? ccrh_val :
        hit_ccrl ? ccrl_val :
        hit_pch  ? cap_pc[23:16] :
        hit_pcm  ? cap_pc[15:8] :
        hit_pcl  ? cap_pc[7:0] : 8'h00;

    // data latched in setup so prdata comes from a flop in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_clear_no_event;
        ec_clear && !cap_event;
    endsequence

    sequence s_fresh_event;
        cap_event ##0 from_adc1;
    endsequence

    chk_pc_capture: assert property (
        do_capture |=> cap_pc == $past(core_ctx.pc))
        else $error("captured pc differs from faulting instruction");

    chk_record_frozen: assert property (
        !ec_zero && !ec_clear |=> $stable(err_code) && $stable(cap_pc))
        else $error("error record changed while non-zero");

    chk_clear_rearm: assert property (
        s_clear_no_event ##1 !cap_event ##1 s_fresh_event |=>
            err_code.initiator_field == avm_pkg::AVM_ITR_ADC1)
        else $error("capture not re-armed after clear");

    chk_clear_zero: assert property (
        s_clear_no_event |=> ec_zero [*2] or (ec_zero ##0 cap_event))
        else $error("clear did not zero the error code");

    chk_cpu_exception: assert property (
        access.valid && from_cpu && illegal |-> machine_exception)
        else $error("illegal core access without exception");

    chk_dbg_no_exc: assert property (
        access.valid && from_dbg |-> !machine_exception
            && (dbg_illegal_access_set == illegal))
        else $error("debug access misreported");

    chk_dma_irq: assert property (
        access.valid && from_adc0 && illegal |->
            adc0_error_irq && !adc1_error_irq && !trig_error_irq)
        else $error("adc0 illegal access irq wrong");

    chk_rsv_write: assert property (
        access.valid && from_cpu && is_store
            && rgn == avm_pkg::AVM_RGN_RSV |-> illegal == modc)
        else $error("reserved write legality wrong for mode");

    chk_unmapped: assert property (
        access.valid && rgn == avm_pkg::AVM_RGN_UNMAP |-> illegal)
        else $error("unmapped access taken as legal");

    chk_ecc_exc: assert property (
        acc_ecc && !from_dbg |-> machine_exception
            ##1 err_code.err_type != 4'h0)
        else $error("ecc fault not raised or recorded");

    chk_pc_readonly: assert property (
        apb_wr && (hit_pch || hit_pcm || hit_pcl) && !do_capture
            |=> $stable(cap_pc))
        else $error("software write changed captured pc");

endmodule
`default_nettype wire

/* sim/avm_initiators.sv */
`timescale 1ns/1ps
`default_nettype none
module avm_initiators (
    input  wire logic              pclk,
    output avm_pkg::avm_access_t   access,
    output avm_pkg::avm_core_ctx_t core_ctx
);
    initial begin
        access = '0;
        core_ctx = '0;
    end

    // one access completes per call, launched just after the edge
    task automatic issue(input int i, k, input logic [23:0] a,
                         input bit ecc, col, input logic [23:0] pc);
        @(posedge pclk);
        access <= '{1'b1, avm_pkg::avm_ini_t'(i),
                    avm_pkg::avm_kind_t'(k), a, ecc, col};
        // condition bits follow the low three pc bits, so the pattern changes with pc[2:0]
        core_ctx <= '{pc, pc[0], pc[1], pc[2]};
        #1;
    endtask

    // released bus flips its address so stale values never look valid
    task automatic idle();
        @(posedge pclk);
        access.valid <= 1'b0;
        access.addr <= ~access.addr;
        core_ctx.pc <= ~core_ctx.pc;
        #1;
    endtask
endmodule
`default_nettype wire

/* sim/access_violation_monitor_test.sv */
`timescale 1ns/1ps
`default_nettype none
module access_violation_monitor_test;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, mode_strap, er, sp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, special_mode, machine_exception;
    logic dbg_ill, dbg_rwf, dbg_debug_read_invalid_flag, adc0_irq, adc1_irq, trig_irq;
    avm_pkg::avm_access_t   access;
    avm_pkg::avm_core_ctx_t core_ctx;
    logic [15:0] rec;
    logic [23:0] pcx, a;
    int n_fail, n_checks, i, k;
    int tgt_of [8] = '{1, 0, 0, 2, 3, 5, 4, 0};

    always #5 pclk = ~pclk;

    avm_top avm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_strap(mode_strap), .access(access), .core_ctx(core_ctx),
        .special_mode(special_mode), .machine_exception(machine_exception),
        .dbg_illegal_access_set(dbg_ill), .dbg_ram_write_fault_set(dbg_rwf),
        .dbg_read_invalid_set(dbg_debug_read_invalid_flag), .adc0_error_irq(adc0_irq),
        .adc1_error_irq(adc1_irq), .trig_error_irq(trig_irq));
    avm_initiators avm_initiators_inst (.pclk(pclk), .access(access),
        .core_ctx(core_ctx));

    task automatic results();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input string s, input logic [31:0] x, y);
        n_checks++;
        if (x !== y) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", s, x, y);
        end
    endtask

    task automatic chk_ev(input logic [6:0] x, y);
        n_checks++;
        if (x !== y) begin
            n_fail++;
            $display("unexpected events expected %b seen %b", x, y);
        end
    endtask

    task automatic apb(input bit w, input logic [7:0] idx,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] x,
                        input string s);
        apb(1'b0, idx, 32'h0);
        chk_val(s, {24'h0, x}, rd);
    endtask

    // 0 reg 1 rsv 2 rsv_ro 3 ram 4 eep 5 ifr 6 pnvm 7 unmapped
    function automatic int rgn(input logic [23:0] x);
        case (x[23:20])
            4'h0: return (x <= 24'h000FFF) ? 0 : 1;
            4'h1: return 2;
            4'h2: return 3;
            4'h3: return 4;
            4'h4: return 5;
            4'h5, 4'h6, 4'h7: return 7;
            default: return 6;
        endcase
    endfunction

    function automatic bit ill(input int i, k, r, input bit col, s);
        bit dma;
        dma = i >= 2;
        if (r == 7) return 1'b1;
        if (col && r >= 4 && r <= 6) return 1'b1;
        if (k == 0) return i != 0 || !(r == 3 || r == 4 || r == 6);
        if (k == 3 && r == 1) return dma || (i == 0 && !s);
        if (k == 3) return !(r == 3 || (r == 0 && !dma));
        return dma && !(r == 3 || r == 4 || r == 6);
    endfunction

    task automatic go(input int i, k, input logic [23:0] x,
                      input bit ecc, col, input logic [23:0] pc);
        int r;
        bit e;
        logic [6:0] v;
        r = rgn(x);
        e = ill(i, k, r, col, sp);
        v = {(i == 0 && e) || (i != 1 && ecc), i == 1 && e,
             i == 1 && ecc && k == 3, i == 1 && ecc && k != 3,
             i == 2 && e, i == 3 && e, i == 4 && e};
        avm_initiators_inst.issue(i, k, x, ecc, col, pc);
        chk_ev(v, {machine_exception, dbg_ill, dbg_rwf, dbg_debug_read_invalid_flag,
                   adc0_irq, adc1_irq, trig_irq});
        // valid marks one completing cycle, so drop it before anything else
        avm_initiators_inst.idle();
        if (i != 1 && (e || ecc) && rec == 16'h0) begin
            rec = {4'(i == 0 ? 1 : i + 1), 4'(tgt_of[r]), 4'(k + 1),
                   e ? 4'h1 : 4'h2};
            pcx = pc;
        end
    endtask

    task automatic rec_check();
        rchk(8'h80, rec[15:8], "error_code_high");
        rchk(8'h81, rec[7:0], "error_code_low");
        if (rec != 16'h0) begin
            rchk(8'h84, pcx[23:16], "captured_pc_high");
            rchk(8'h85, pcx[15:8], "captured_pc_middle");
            rchk(8'h86, pcx[7:0], "captured_pc_low");
            rchk(8'h82, {pcx[0], 7'h0}, "captured_ccr_high");
            rchk(8'h83, {1'b0, pcx[1], 1'b0, pcx[2], 4'h0},
                 "captured_ccr_low");
        end
    endtask

    initial begin
        {psel, penable, pwrite, presetn, mode_strap} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rec = 16'h0;
        sp = 1'b1;
        i = $urandom(66895);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 chk_val("special_mode", 32'h1, 32'(special_mode));
        rec_check();
        go(0, 3, 24'h001000, 1'b0, 1'b0, 24'h123456);
        apb(1'b1, 8'h70, 32'h00000080);
        sp = 1'b0;
        #1 chk_val("special_mode", 32'h0, 32'(special_mode));
        go(0, 3, 24'h001000, 1'b0, 1'b0, 24'h0ABCDE);
        go(2, 3, 24'h000100, 1'b0, 1'b0, 24'h111111);
        avm_initiators_inst.idle();
        rec_check();
        apb(1'b1, 8'h84, 32'h000000FF);
        rec_check();
        apb(1'b1, 8'h81, 32'h0000FFFF);
        rec = 16'h0;
        rec_check();
        for (int j = 0; j < 40; j++) begin
            repeat (8) begin
                i = $urandom_range(4);
                k = $urandom_range(3);
                a = {4'($urandom_range(15)), 20'($urandom)};
                if (a[23:20] == 4'h0 && $urandom_range(1)) a[19:12] = 8'h0;
                if (k == 0 && &a[19:3]) a[3] = 1'b0;
                go(i, k, a, $urandom_range(3) == 0, $urandom_range(7) == 0,
                   24'($urandom));
            end
            avm_initiators_inst.idle();
            rec_check();
            apb(1'b1, j[0] ? 8'h81 : 8'h80, 32'h0000FFFF);
            rec = 16'h0;
        end
        rchk(8'h80, 8'h0, "error_code_high");
        apb(1'b0, 8'h20, 32'h0);
        chk_val("pslverr", 32'h1, 32'(er));
        chk_val("prdata", 32'h0, rd);
        results();
    end
endmodule
`default_nettype wire
